// ---- shared/tic_pkg.sv ----
/*
  Shared constants and types for the edge capture engine.
  Assumes a single 10 MHz sampling clock; all times are folded into cycles here.
*/
package tic_pkg;

  // Clock and derived cycle period
  localparam int CLK_HZ = 10_000_000;
  localparam int PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);

  // Documented times, in picoseconds
  localparam int MIN_SEP_PS = 12_500;
  localparam int SHORT_PAIR_PS = 8_000;
  localparam int RECOVERY_PS = 30_000;

  // Least times round up, never below one cycle
  localparam int MIN_SEP_RAW = (MIN_SEP_PS + PERIOD_PS - 1) / PERIOD_PS;
  localparam int MIN_SEP_CYC = (MIN_SEP_RAW < 1) ? 1 : MIN_SEP_RAW;
  localparam int SHORT_PAIR_RAW = (SHORT_PAIR_PS + PERIOD_PS - 1) / PERIOD_PS;
  localparam int SHORT_PAIR_CYC = (SHORT_PAIR_RAW < 1) ? 1 : SHORT_PAIR_RAW;
  localparam int RECOVERY_RAW = (RECOVERY_PS + PERIOD_PS - 1) / PERIOD_PS;
  localparam int RECOVERY_CYC = (RECOVERY_RAW < 1) ? 1 : RECOVERY_RAW;

  // Sizes
  localparam int HIST_BINS = 2048;
  localparam int DATA_W = 32;
  localparam int GAP_W = 8;
  localparam int RES_W = 4;
  localparam int SKIP_W = 3;

  // Operation status condition word
  localparam int STAT_W = 16;
  localparam int STAT_DONE_BIT = 4;
  localparam logic [STAT_W-1:0] STAT_RESET = 16'h0000;

  // Pacing scrambler
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

  // Measurement functions
  typedef enum logic [1:0] {
    SEQUENTIAL_INTERVAL_FUNCTION,
    INTERVAL_HISTOGRAM_FUNCTION,
    EDGE_STAMP_FUNCTION
  } func_t;

  // Capture engine states
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_FETCH} state_t;

endpackage : tic_pkg

// ---- core/pair_buffer.sv ----
/*
  Small FIFO between result memory and the result port.
  Assumes one clock, synchronous reset; the reader may stall at any time.
*/
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2,
  parameter int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot_reg [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic [PW:0] cnt_next;
  logic push;
  logic pop;
  logic [PW-1:0] rp_next;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rp_next = !pop ? rp_reg : ((rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1);

  // Head word kept in a flop; a push into an empty buffer goes straight to it
  always_ff @(posedge clk) begin
    out_data <= (push && wp_reg == rp_next) ? in_data : slot_reg[rp_next];
  end

  // Occupancy, full and empty kept as flops
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != (PW+1)'(DEPTH));
      out_valid <= (cnt_next != '0);
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      rp_reg <= rp_next;
    end
  end

  // Storage needs no reset; empty flag guards it
  always_ff @(posedge clk) begin
    if (push) begin
      slot_reg[wp_reg] <= in_data;
    end
  end

endmodule : pair_buffer

// ---- core/time_interval_capture.sv ----
/*
  Edge capture engine of the analyzer_unit: interval, histogram and stamp capture.
  Assumes measurement, trigger and command inputs are synchronous to clk and
  that the inputs are already comparator outputs at the chosen threshold.
*/
// Summary of operation
// - Single-channel edges at least 12.5 ns apart are all recorded.
// - A single-channel edge closer than 12.5 ns may be dropped.
// - Short-pair mode measures single-channel pairs down to 8 ns.
// - Each short-pair measurement is followed by about 30 ns recovery.
// - Short-pair results hold only the short intervals; recovery gaps are not stored.
// - Random pacing with short-pair samples intervals in fair proportion.
// - Sequential modes store results in acquisition order.
// - Single-source histogram counts intervals into 2048 bins scaled by resolution.
// - Dual-source histogram bins input 1 to input 2 intervals.
// - Histograms sort at full data rate and keep no sequence.
// - Frequency results come only from sequential interval acquisitions.
// - Single-source stamps give elapsed time since the reference edge.
// - Single-source stamp reference is trigger edge or first measured edge, by setting.
// - An edge counts only with the configured polarity at threshold.
// - Interval results can be derived from stored stamps at fetch.
// - After initiate, capture waits for the trigger condition.
// - Results stay in memory until the next initiate or read; a fetch copies a range out.
// - Completion shows on bit 4 of the operation status word.
// - Completion can raise a service request.
// - Configure sets the function without starting an acquisition.
// - Read acts as initiate followed at once by fetch.
// - Dual stamps alternate input 1, input 2, referenced to first input 1.
`timescale 1ns/1ps
module time_interval_capture #(
  parameter int MEM_DEPTH = tic_pkg::HIST_BINS,
  parameter int ADDR_W = $clog2(MEM_DEPTH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Measurement and trigger inputs
  input wire logic meas_in1,
  input wire logic meas_in2,
  input wire logic trig_in,
  // Configuration, taken on cfg_req
  input wire logic cfg_req,
  input wire tic_pkg::func_t cfg_func,
  input wire logic cfg_dual,
  input wire logic cfg_src2,
  input wire logic cfg_short_pair,
  input wire logic cfg_rand_pace,
  input wire logic cfg_ref_trig,
  input wire logic cfg_in1_rise,
  input wire logic cfg_in2_rise,
  input wire logic cfg_trig_rise,
  input wire logic cfg_free_run,
  input wire logic cfg_srq_en,
  input wire logic [tic_pkg::RES_W-1:0] cfg_res_shift,
  input wire logic [ADDR_W:0] cfg_acq_len,
  // Commands
  input wire logic init_req,
  input wire logic read_req,
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_start,
  input wire logic [ADDR_W:0] fetch_count,
  input wire logic fetch_as_interval,
  // Result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [tic_pkg::DATA_W-1:0] res_data,
  // Status
  output logic [tic_pkg::STAT_W-1:0] op_status_reg,
  output logic srq_reg,
  output logic stamp_ovf_reg,
  output logic freq_avail_reg
);
  import tic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  state_t state_reg;
  func_t func_reg;
  func_t acq_func_reg;
  logic dual_reg, src2_reg, sp_reg, rp_reg, ref_trig_reg, free_reg, srq_en_reg;
  logic trig_rise_reg, trig_d_reg;
  logic [1:0] rise_reg, pin_d_reg, edge_hit, pin_now;
  logic [RES_W-1:0] res_reg;
  logic [ADDR_W:0] len_reg, cnt_reg, cnt_next;
  logic [ADDR_W-1:0] fa_reg;
  logic [ADDR_W:0] fr_reg;
  logic fint_reg, fetch_pend_reg;
  logic [DATA_W-1:0] ts_reg, ref_reg, start_reg;
  logic ref_ok_reg, pend_reg, alt_reg;
  logic [GAP_W-1:0] since_reg, rec_reg;
  logic [SKIP_W-1:0] skip_reg;
  logic [15:0] lfsr_reg;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [MEM_DEPTH-1:0] vld_reg;
  logic start_go, trig_hit, ch_edge, acc_edge, meas_v, acq_end, is_hist;
  logic [DATA_W-1:0] meas_val, bin_word, fetch_word;
  logic [ADDR_W-1:0] bin_addr, waddr;
  logic push_v, push_ready;

  function automatic logic [DATA_W-1:0] mem_rd(input logic [ADDR_W-1:0] a);
    mem_rd = vld_reg[a] ? mem[a] : '0;
  endfunction : mem_rd

  ////////////////////////////////////////////////////////////////////////////
  // Edge qualification

  assign pin_now = {meas_in2, meas_in1};

  for (genvar ch = 0; ch < 2; ch++) begin : g_edge
    assign edge_hit[ch] = rise_reg[ch] ? (pin_now[ch] && !pin_d_reg[ch])
                                       : (!pin_now[ch] && pin_d_reg[ch]);
  end

  // Previous levels load through reset too, so a pin resting high gives no false edge
  always_ff @(posedge clk) begin
    pin_d_reg <= pin_now;
    trig_d_reg <= trig_in;
  end

  // trigger condition; free run fires at once
  assign trig_hit = free_reg || (trig_rise_reg ? (trig_in && !trig_d_reg) : (!trig_in && trig_d_reg));
  assign ch_edge = src2_reg ? edge_hit[1] : edge_hit[0];
  assign acc_edge = ch_edge && (since_reg >= GAP_W'(MIN_SEP_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // Configuration

  // configure only while idle, reset to single-source intervals
  always_ff @(posedge clk) begin
    if (srst) begin
      func_reg <= SEQUENTIAL_INTERVAL_FUNCTION;
      {dual_reg, src2_reg, sp_reg, rp_reg, ref_trig_reg} <= '0;
      {free_reg, srq_en_reg, trig_rise_reg} <= 3'h7;
      rise_reg <= 2'h3;
      res_reg <= '0;
      len_reg <= (ADDR_W+1)'(MEM_DEPTH);
    end else if (cfg_req && state_reg == ST_IDLE) begin
      func_reg <= cfg_func;
      {dual_reg, src2_reg, sp_reg, rp_reg, ref_trig_reg} <=
        {cfg_dual, cfg_src2, cfg_short_pair, cfg_rand_pace, cfg_ref_trig};
      {free_reg, srq_en_reg, trig_rise_reg} <= {cfg_free_run, cfg_srq_en, cfg_trig_rise};
      rise_reg <= {cfg_in2_rise, cfg_in1_rise};
      res_reg <= cfg_res_shift;
      len_reg <= cfg_acq_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing

  assign start_go = (init_req || read_req) && state_reg == ST_IDLE;
  assign push_v = (state_reg == ST_FETCH) && (fr_reg != '0);

  // arm, run, then fetch when a read is pending
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_go) begin
            state_reg <= ST_ARMED;
          end else if (fetch_req) begin
            state_reg <= ST_FETCH;
          end
        end
        ST_ARMED: begin
          if (trig_hit) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (acq_end) begin
            state_reg <= fetch_pend_reg ? ST_FETCH : ST_IDLE;
          end
        end
        ST_FETCH: begin
          if (fr_reg == '0) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fa_reg <= '0;
      fr_reg <= '0;
      fint_reg <= 1'b0;
      fetch_pend_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && (read_req || fetch_req)) begin
      fa_reg <= fetch_start;
      fr_reg <= fetch_count;
      fint_reg <= fetch_as_interval;
      fetch_pend_reg <= read_req;
    end else if (push_v && push_ready) begin
      fa_reg <= fa_reg + 1'b1;
      fr_reg <= fr_reg - 1'b1;
      fetch_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and per-mode tracking

  // stamp counter with sticky wrap flag; a wrap beats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      ts_reg <= '0;
      stamp_ovf_reg <= 1'b0;
    end else begin
      if (state_reg == ST_RUN) begin
        ts_reg <= ts_reg + 1'b1;
      end else begin
        ts_reg <= (state_reg == ST_ARMED && trig_hit) ? DATA_W'(1) : '0;
      end
      if (state_reg == ST_RUN && ts_reg == '1) begin
        stamp_ovf_reg <= 1'b1;
      end else if (start_go) begin
        stamp_ovf_reg <= 1'b0;
      end
    end
  end

  // Edge tracking: reference, pending start, recovery and pacing skip
  always_ff @(posedge clk) begin
    if (srst || state_reg != ST_RUN) begin
      ref_ok_reg <= 1'b0;
      ref_reg <= '0;
      start_reg <= '0;
      pend_reg <= 1'b0;
      alt_reg <= 1'b0;
      rec_reg <= '0;
      skip_reg <= '0;
      since_reg <= '1;
    end else begin
      since_reg <= acc_edge ? '0 : ((since_reg == '1) ? since_reg : since_reg + 1'b1);
      // reference taken from trigger or first measured edge
      if (!ref_ok_reg) begin
        if (func_reg == EDGE_STAMP_FUNCTION && dual_reg) begin
          ref_ok_reg <= edge_hit[0];
        end else begin
          ref_ok_reg <= ref_trig_reg || acc_edge;
        end
        ref_reg <= ref_trig_reg && !dual_reg ? '0 : ts_reg;
      end
      // strict input 1 / input 2 alternation
      if (func_reg == EDGE_STAMP_FUNCTION && dual_reg && meas_v) begin
        alt_reg <= !alt_reg;
      end
      if (rec_reg != '0) begin
        rec_reg <= rec_reg - 1'b1;
      end
      if (dual_reg) begin
        if (edge_hit[1]) begin
          pend_reg <= 1'b0;
        end else if (edge_hit[0] && !pend_reg) begin
          pend_reg <= 1'b1;
          start_reg <= ts_reg;
        end
      end else if (sp_reg) begin
        // first edge opens, second closes, then recovery
        if (acc_edge && rec_reg == '0) begin
          if (skip_reg != '0) begin
            skip_reg <= skip_reg - 1'b1;
          end else if (!pend_reg) begin
            pend_reg <= 1'b1;
            start_reg <= ts_reg;
          end else begin
            pend_reg <= 1'b0;
            rec_reg <= GAP_W'(RECOVERY_CYC);
            // random number of skipped edges before the next pair
            skip_reg <= rp_reg ? lfsr_reg[SKIP_W-1:0] : '0;
          end
        end
      end else if (acc_edge) begin
        // every accepted edge opens the next interval; all but the first also close one
        pend_reg <= 1'b1;
        start_reg <= ts_reg;
      end
    end
  end

  // Pacing scrambler runs freely
  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr_reg <= LFSR_SEED;
    end else begin
      lfsr_reg <= {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? LFSR_TAPS : 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement result for this cycle

  always_comb begin
    meas_v = 1'b0;
    meas_val = '0;
    if (state_reg == ST_RUN) begin
      if (func_reg == EDGE_STAMP_FUNCTION) begin
        // elapsed time since the reference edge
        if (dual_reg) begin
          meas_v = alt_reg ? edge_hit[1] : edge_hit[0];
        end else begin
          meas_v = acc_edge;
        end
        meas_val = (ref_ok_reg || (ref_trig_reg && !dual_reg)) ? ts_reg - ref_reg : '0;
      end else if (dual_reg) begin
        // input 1 to input 2, same-cycle pair reads as zero
        meas_v = edge_hit[1] && (pend_reg || edge_hit[0]);
        meas_val = pend_reg ? ts_reg - start_reg : '0;
      end else if (sp_reg) begin
        meas_v = acc_edge && pend_reg && rec_reg == '0 && skip_reg == '0;
        meas_val = ts_reg - start_reg;
      end else begin
        meas_v = acc_edge && pend_reg;
        meas_val = ts_reg - start_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result memory

  assign is_hist = (func_reg == INTERVAL_HISTOGRAM_FUNCTION);
  // bin width set by resolution shift, overflow lands in the last bin
  assign bin_word = meas_val >> res_reg;
  assign bin_addr = (bin_word > DATA_W'(HIST_BINS - 1)) ? ADDR_W'(HIST_BINS - 1) : bin_word[ADDR_W-1:0];
  assign waddr = is_hist ? bin_addr : cnt_reg[ADDR_W-1:0];
  assign cnt_next = cnt_reg + 1'b1;
  assign acq_end = meas_v && ((cnt_next >= len_reg) || (!is_hist && cnt_next == (ADDR_W+1)'(MEM_DEPTH)));

  // sequential store or same-cycle bin increment
  always_ff @(posedge clk) begin
    if (meas_v) begin
      mem[waddr] <= is_hist ? mem_rd(bin_addr) + 1'b1 : meas_val;
    end
  end

  // valid bits empty the memory without a sweep
  always_ff @(posedge clk) begin
    if (srst || start_go) begin
      vld_reg <= '0;
      cnt_reg <= '0;
    end else if (meas_v) begin
      vld_reg[waddr] <= 1'b1;
      cnt_reg <= cnt_next;
    end
  end

  // completion status, service request, frequency availability
  always_ff @(posedge clk) begin
    if (srst) begin
      op_status_reg <= STAT_RESET;
      srq_reg <= 1'b0;
      freq_avail_reg <= 1'b0;
      acq_func_reg <= SEQUENTIAL_INTERVAL_FUNCTION;
    end else if (state_reg == ST_RUN && acq_end) begin
      op_status_reg[STAT_DONE_BIT] <= 1'b1;
      srq_reg <= srq_en_reg;
      freq_avail_reg <= (func_reg == SEQUENTIAL_INTERVAL_FUNCTION) && !dual_reg && !sp_reg && !rp_reg;
    end else if (start_go) begin
      op_status_reg[STAT_DONE_BIT] <= 1'b0;
      srq_reg <= 1'b0;
      freq_avail_reg <= 1'b0;
      acq_func_reg <= func_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch path

  // stamps turned into intervals by differencing neighbours
  assign fetch_word = (fint_reg && acq_func_reg == EDGE_STAMP_FUNCTION && fa_reg != '0)
                      ? mem_rd(fa_reg) - mem_rd(fa_reg - 1'b1) : mem_rd(fa_reg);

  // Two-entry buffer so a stalled reader loses no word
  pair_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(2)
  ) u_out_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(push_v),
    .in_ready(push_ready),
    .in_data(fetch_word),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

endmodule : time_interval_capture

// ---- test/tic_sva.sv ----
/*
  Checker for the capture engine's status bits and result stream.
  Assumes it is bound to time_interval_capture and sees only its ports.
*/
`timescale 1ns/1ps
module tic_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Commands
  input wire logic init_req,
  input wire logic read_req,
  input wire logic fetch_req,
  // Result stream
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [tic_pkg::DATA_W-1:0] res_data,
  // Status
  input wire logic [tic_pkg::STAT_W-1:0] op_status_reg,
  input wire logic srq_reg
);
  import tic_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Remembers that a fetch was ever asked for since reset
  logic fetch_seen_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      fetch_seen_reg <= 1'b0;
    end else if (fetch_req || read_req) begin
      fetch_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Steps of the stream and completion
  sequence s_stall;
    res_valid && !res_ready;
  endsequence
  sequence s_done_rise;
    $rose(op_status_reg[STAT_DONE_BIT]);
  endsequence

  AST_RESET_CLEAR: assert property ($fell(srst) |-> !srq_reg && !res_valid && op_status_reg == STAT_RESET)
    else $error("status not clear after reset");
  AST_ONLY_DONE_BIT: assert property ((op_status_reg & ~(16'h0001 << STAT_DONE_BIT)) == 16'h0000)
    else $error("status bit other than completion set");
  AST_DONE_STANDS: assert property (op_status_reg[STAT_DONE_BIT] && !init_req && !read_req |=>
    op_status_reg[STAT_DONE_BIT]) else $error("completion dropped without a new start");
  AST_SRQ_NEEDS_DONE: assert property (srq_reg |-> op_status_reg[STAT_DONE_BIT])
    else $error("service request without completion");
  AST_SRQ_AT_DONE: assert property ($rose(srq_reg) |-> s_done_rise)
    else $error("service request not raised at completion");
  AST_DONE_QUIET: assert property (s_done_rise |-> !res_valid)
    else $error("results offered at completion without fetch");
  AST_STALL_HOLDS: assert property (s_stall |=> res_valid && $stable(res_data))
    else $error("result word changed during stall");
  AST_FETCH_FIRST: assert property (res_valid |-> fetch_seen_reg)
    else $error("result word offered before any fetch");
endmodule : tic_sva

// ---- test/meas_source.sv ----
/*
  Behavioural model of the signals under test: two comparator outputs
  and a trigger line, all moved just after rising clock edges.
*/
`timescale 1ns/1ps
module meas_source (
  // Clock
  input wire logic clk,
  // Lines toward the engine
  output logic meas_in1,
  output logic meas_in2,
  output logic trig_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Input 2 rests high, so its first change is a falling edge
  initial begin
    meas_in1 <= 1'b0;
    meas_in2 <= 1'b1;
    trig_in <= 1'b0;
  end

  // Inverts one line for a cycle; the next pulse starts gap cycles later
  task automatic pulse(input int ch, input int gap);
    @(posedge clk);
    flip(ch);
    @(posedge clk);
    flip(ch);
    repeat (gap - 2) @(posedge clk);
  endtask : pulse

  task automatic flip(input int ch);
    case (ch)
      1: meas_in1 <= ~meas_in1;
      2: meas_in2 <= ~meas_in2;
      default: trig_in <= ~trig_in;
    endcase
  endtask : flip
endmodule : meas_source

// ---- test/tb.sv ----
/*
  Self-checking bench for the capture engine: one task per scenario.
  Assumes the meas_source model on the inputs and the tic_sva checker bound.
*/
`timescale 1ns/1ps
module tb;
  import tic_pkg::*;

  logic clk = 1'b0, srst = 1'b1, meas_in1, meas_in2, trig_in;
  logic cfg_req = 1'b0, cfg_dual = 1'b0, cfg_src2 = 1'b0, cfg_short_pair = 1'b0, cfg_rand_pace = 1'b0;
  logic cfg_ref_trig = 1'b0, cfg_in1_rise = 1'b1, cfg_in2_rise = 1'b1, cfg_trig_rise = 1'b1;
  logic cfg_free_run = 1'b1, cfg_srq_en = 1'b1, init_req = 1'b0, read_req = 1'b0, fetch_req = 1'b0;
  logic fetch_as_interval = 1'b0, res_ready = 1'b0, res_valid, srq_reg, stamp_ovf_reg, freq_avail_reg;
  func_t cfg_func = SEQUENTIAL_INTERVAL_FUNCTION;
  logic [3:0] cfg_res_shift = 4'h0;
  logic [11:0] cfg_acq_len = 12'h004, fetch_count = 12'h000;
  logic [10:0] fetch_start = 11'h000;
  logic [31:0] res_data;
  logic [15:0] op_status_reg;
  logic [31:0] got_q [$];
  int n_mismatch = 0, samples_checked = 0, cycles = 0;

  always #50 clk = ~clk;

  time_interval_capture dut_u (.clk, .srst, .meas_in1, .meas_in2, .trig_in, .cfg_req, .cfg_func, .cfg_dual,
    .cfg_src2, .cfg_short_pair, .cfg_rand_pace, .cfg_ref_trig, .cfg_in1_rise, .cfg_in2_rise, .cfg_trig_rise,
    .cfg_free_run, .cfg_srq_en, .cfg_res_shift, .cfg_acq_len, .init_req, .read_req, .fetch_req, .fetch_start,
    .fetch_count, .fetch_as_interval, .res_valid, .res_ready, .res_data, .op_status_reg, .srq_reg,
    .stamp_ovf_reg, .freq_avail_reg);
  meas_source src_u (.clk, .meas_in1, .meas_in2, .trig_in);

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, far above the few dozen cycles each scenario needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // Reset, then configure; histograms run with service request off
  task automatic setup(input func_t f, input logic s2, input logic du, input logic fr, input int sh, input int len);
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk) cfg_req <= 1'b1;
    check("reset", {op_status_reg, 13'h0, srq_reg, stamp_ovf_reg, res_valid}, 32'h0);
    cfg_func <= f;
    cfg_src2 <= s2;
    cfg_in2_rise <= s2;
    cfg_dual <= du;
    cfg_free_run <= fr;
    cfg_srq_en <= (f != INTERVAL_HISTOGRAM_FUNCTION);
    cfg_res_shift <= 4'(sh);
    cfg_acq_len <= 12'(len);
    @(posedge clk) cfg_req <= 1'b0;
  endtask : setup

  // Command pulse: 0 initiate, 1 read, 2 fetch
  task automatic cmd(input int which, input int start, input int cnt, input logic as_int);
    @(posedge clk) init_req <= (which == 0);
    read_req <= (which == 1);
    fetch_req <= (which == 2);
    fetch_start <= 11'(start);
    fetch_count <= 12'(cnt);
    fetch_as_interval <= as_int;
    @(posedge clk) init_req <= 1'b0;
    read_req <= 1'b0;
    fetch_req <= 1'b0;
  endtask : cmd

  // Takes n words, stalling one cycle between them
  task automatic collect(input int n);
    int k;
    got_q.delete();
    for (int i = 0; i < n; i++) begin
      res_ready <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (!(res_valid === 1'b1 && res_ready === 1'b1) && k < 300);
      check("res handshake", 32'(res_valid === 1'b1 && res_ready === 1'b1), 32'h1);
      res_ready <= 1'b0;
      got_q.push_back(res_data);
      @(posedge clk);
    end
  endtask : collect

  task automatic wait_done();
    int k;
    k = 0;
    while (op_status_reg[STAT_DONE_BIT] !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    check("done bit", 32'(op_status_reg), 32'h0010);
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_sequential();
    logic [31:0] e [4] = '{32'h3, 32'h5, 32'h2, 32'h4};
    setup(SEQUENTIAL_INTERVAL_FUNCTION, 1'b0, 1'b0, 1'b0, 0, 4);
    cmd(0, 0, 0, 1'b0);
    src_u.pulse(1, 3);
    src_u.pulse(1, 7);
    check("before trigger", 32'(op_status_reg), 32'h0);
    src_u.pulse(0, 4);
    for (int i = 0; i < 5; i++) src_u.pulse(1, (i < 4) ? int'(e[i]) : 3);
    wait_done();
    check("srq", 32'(srq_reg), 32'h1);
    check("freq", 32'(freq_avail_reg), 32'h1);
    cmd(2, 0, 4, 1'b0);
    collect(4);
    foreach (e[i]) check("interval", got_q[i], e[i]);
  endtask : t_sequential

  task automatic t_histogram();
    logic [31:0] e [4] = '{32'h0, 32'h2, 32'h0, 32'h1};
    setup(INTERVAL_HISTOGRAM_FUNCTION, 1'b1, 1'b0, 1'b1, 1, 3);
    repeat (3) src_u.pulse(2, 4);
    check("configured only", 32'(op_status_reg), 32'h0);
    cmd(0, 0, 0, 1'b0);
    src_u.pulse(2, 4);
    src_u.pulse(2, 5);
    src_u.pulse(2, 8);
    src_u.pulse(2, 3);
    wait_done();
    check("srq disabled", 32'(srq_reg), 32'h0);
    check("freq", 32'(freq_avail_reg), 32'h0);
    cmd(2, 1, 4, 1'b0);
    collect(4);
    foreach (e[i]) check("bin", got_q[i], e[i]);
  endtask : t_histogram

  task automatic t_stamp();
    logic [31:0] e [3] = '{32'h0, 32'h3, 32'h7};
    logic [31:0] d [3] = '{32'h0, 32'h3, 32'h4};
    setup(EDGE_STAMP_FUNCTION, 1'b0, 1'b0, 1'b1, 0, 3);
    cmd(0, 0, 0, 1'b0);
    src_u.pulse(1, 3);
    src_u.pulse(1, 4);
    src_u.pulse(1, 3);
    wait_done();
    cmd(2, 0, 3, 1'b0);
    collect(3);
    foreach (e[i]) check("stamp", got_q[i], e[i]);
    cmd(2, 0, 3, 1'b1);
    collect(3);
    foreach (d[i]) check("stamp interval", got_q[i], d[i]);
  endtask : t_stamp

  task automatic t_dual_read();
    logic [31:0] e [4] = '{32'h0, 32'h2, 32'h5, 32'h7};
    setup(EDGE_STAMP_FUNCTION, 1'b0, 1'b1, 1'b1, 0, 4);
    cmd(1, 0, 4, 1'b0);
    // Input 2 first is not a stamp, input 1 leads
    src_u.pulse(2, 3);
    src_u.pulse(1, 2);
    src_u.pulse(2, 3);
    src_u.pulse(1, 2);
    src_u.pulse(2, 3);
    collect(4);
    foreach (e[i]) check("dual stamp", got_q[i], e[i]);
  endtask : t_dual_read

  // Only the pairs are intervals; the gap between pairs is not recorded
  task automatic t_short_pair();
    logic [31:0] e [2] = '{32'h2, 32'h3};
    cfg_short_pair <= 1'b1;
    setup(SEQUENTIAL_INTERVAL_FUNCTION, 1'b0, 1'b0, 1'b1, 0, 2);
    cfg_short_pair <= 1'b0;
    cmd(0, 0, 0, 1'b0);
    src_u.pulse(1, 2);
    src_u.pulse(1, 5);
    src_u.pulse(1, 3);
    src_u.pulse(1, 3);
    wait_done();
    check("freq", 32'(freq_avail_reg), 32'h0);
    cmd(2, 0, 2, 1'b0);
    collect(2);
    foreach (e[i]) check("short pair", got_q[i], e[i]);
  endtask : t_short_pair

  initial begin
    t_sequential();
    t_histogram();
    t_stamp();
    t_dual_read();
    t_short_pair();
    tally_and_finish();
  end
endmodule : tb

bind time_interval_capture tic_sva chk_u (.clk, .srst, .init_req, .read_req, .fetch_req, .res_valid,
  .res_ready, .res_data, .op_status_reg, .srq_reg);
